// ==== core/context_switch_sequencer.sv ====
// Purpose: Machine-cycle sequencer for reset, load and interrupt context switches
// Assumes: One machine cycle per sys_clk; memory answers reads in the same cycle
// Notes:   Core supplies status, PC and base; this block returns the new context
// Functional notes
// - Reset held three cycles; sequence starts right after
// - Reset: drive zeros, then read base at 0
// - Reset: write status into status slot
// - Reset: write PC plus two into slot 14
// - Reset: write old base into slot 13
// - Load: one ALU cycle, read base at FFFC
// - Load: save three slots, read PC at FFFE
// - Interrupt: one ALU cycle, read vector base
// - Interrupt: save three slots, read vector PC
// - Interrupt: eleven cycles, last ALU cycle idle
// - Load and interrupt start at instruction boundary
`timescale 1ns/1ns
module context_switch_sequencer #(
  parameter int unsigned DATA_W = ctx_switch_pkg::DATA_W
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              reset_pin_n,
  input  wire logic              load_req,
  input  wire logic              intr_req,
  input  wire logic [DATA_W-1:0] intr_vector_addr,
  input  wire logic              instr_last_cycle,
  input  wire logic [DATA_W-1:0] cur_status,
  input  wire logic [DATA_W-1:0] cur_pc,
  input  wire logic [DATA_W-1:0] cur_base,
  input  wire logic [DATA_W-1:0] data_bus_in,
  output logic      [DATA_W-1:0] address_bus,
  output logic      [DATA_W-1:0] data_bus_out,
  output logic                   data_bus_oe_n,
  output logic                   mem_read,
  output logic                   mem_write,
  output logic                   seq_busy,
  output logic                   intr_ack,
  output logic                   load_ack,
  output logic                   ctx_update,
  output logic      [DATA_W-1:0] new_base,
  output logic      [DATA_W-1:0] new_pc,
  output logic                   core_hold
);
  ctx_switch_pkg::seq_state_t  state_ff;
  ctx_switch_pkg::seq_state_t  nxt_state;
  ctx_switch_pkg::switch_src_t src_ff;
  ctx_switch_pkg::switch_src_t nxt_src;
  logic [3:0]        cyc_ff;
  logic [3:0]        nxt_cyc;
  logic [DATA_W-1:0] base_ff;
  logic [DATA_W-1:0] nxt_base;
  logic [DATA_W-1:0] pc_ff;
  logic [DATA_W-1:0] nxt_pc;
  logic [DATA_W-1:0] old_status_ff;
  logic [DATA_W-1:0] nxt_old_status;
  logic [DATA_W-1:0] old_pc_ff;
  logic [DATA_W-1:0] nxt_old_pc;
  logic [DATA_W-1:0] old_base_ff;
  logic [DATA_W-1:0] nxt_old_base;
  logic [DATA_W-1:0] vec_ff;
  logic [DATA_W-1:0] nxt_vec;
  logic [DATA_W-1:0] addr_ff;
  logic [DATA_W-1:0] nxt_addr;
  logic [DATA_W-1:0] dout_ff;
  logic [DATA_W-1:0] nxt_dout;
  logic              oe_n_ff;
  logic              nxt_oe_n;
  logic              rd_ff;
  logic              nxt_rd;
  logic              wr_ff;
  logic              nxt_wr;
  logic              upd_ff;
  logic              nxt_upd;
  logic              reset_active;
  logic              reset_release;
  logic [DATA_W-1:0] slot15_addr;
  logic [DATA_W-1:0] slot14_addr;
  logic [DATA_W-1:0] slot13_addr;
  logic [3:0]        seq_len;
  logic [3:0]        step;
  logic              start_exc;

  reset_release_detect u_rst (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .reset_pin_n   (reset_pin_n),
    .reset_active  (reset_active),
    .reset_release (reset_release)
  );

  slot_address_gen u_slots (
    .base             (base_ff),
    .status_slot_addr (slot15_addr),
    .return_slot_addr (slot14_addr),
    .saved_base_addr  (slot13_addr)
  );

  // Reset runs two extra leading ALU cycles; map it onto the shared step numbering
  assign seq_len   = (src_ff == ctx_switch_pkg::SRC_RESET) ? ctx_switch_pkg::RESET_LEN
                                                           : ctx_switch_pkg::EXC_LEN;
  assign step      = (src_ff == ctx_switch_pkg::SRC_RESET) ? cyc_ff - 4'h2 : cyc_ff;
  assign start_exc = instr_last_cycle && (load_req || intr_req);

  always_comb begin
    nxt_state      = state_ff;
    nxt_src        = src_ff;
    nxt_cyc        = cyc_ff;
    nxt_base       = base_ff;
    nxt_pc         = pc_ff;
    nxt_old_status = old_status_ff;
    nxt_old_pc     = old_pc_ff;
    nxt_old_base   = old_base_ff;
    nxt_vec        = vec_ff;
    nxt_addr       = addr_ff;
    nxt_dout       = dout_ff;
    nxt_oe_n       = 1'b1;
    nxt_rd         = 1'b0;
    nxt_wr         = 1'b0;
    nxt_upd        = 1'b0;
    unique case (state_ff)
      ctx_switch_pkg::ST_HOLD: begin
        if (reset_release) begin
          nxt_state = ctx_switch_pkg::ST_SEQ;
          nxt_src   = ctx_switch_pkg::SRC_RESET;
          nxt_cyc   = 4'h1;
          nxt_old_status = cur_status;
          nxt_old_pc     = cur_pc;
          nxt_old_base   = cur_base;
        end
      end
      ctx_switch_pkg::ST_RUN: begin
        if (start_exc) begin
          nxt_state      = ctx_switch_pkg::ST_SEQ;
          nxt_src        = load_req ? ctx_switch_pkg::SRC_LOAD : ctx_switch_pkg::SRC_INTR;
          nxt_cyc        = 4'h1;
          nxt_vec        = intr_vector_addr;
          nxt_old_status = cur_status;
          nxt_old_pc     = cur_pc;
          nxt_old_base   = cur_base;
        end
      end
      ctx_switch_pkg::ST_SEQ: begin
        nxt_cyc = cyc_ff + 4'h1;
        if (src_ff == ctx_switch_pkg::SRC_RESET && cyc_ff == 4'h2) begin
          nxt_addr = ctx_switch_pkg::ZERO_WORD;
          nxt_dout = ctx_switch_pkg::ZERO_WORD;
          nxt_oe_n = 1'b0;
        end
        if (cyc_ff < seq_len) begin
          unique case (step + 4'h1)
            4'h2: begin
              nxt_rd = 1'b1;
              unique case (src_ff)
                ctx_switch_pkg::SRC_RESET: nxt_addr = ctx_switch_pkg::RESET_WP_ADDR;
                ctx_switch_pkg::SRC_LOAD:  nxt_addr = ctx_switch_pkg::LOAD_WP_ADDR;
                default:                   nxt_addr = vec_ff;
              endcase
            end
            4'h4: begin
              nxt_wr   = 1'b1;
              nxt_oe_n = 1'b0;
              nxt_addr = slot15_addr;
              nxt_dout = old_status_ff;
            end
            4'h5: begin
              nxt_oe_n = 1'b0;
              nxt_dout = old_pc_ff;
            end
            4'h6: begin
              nxt_wr   = 1'b1;
              nxt_oe_n = 1'b0;
              nxt_addr = slot14_addr;
              nxt_dout = old_pc_ff + ctx_switch_pkg::PC_STEP;
            end
            4'h7: begin
              nxt_addr = slot13_addr;
            end
            4'h8: begin
              nxt_wr   = 1'b1;
              nxt_oe_n = 1'b0;
              nxt_addr = slot13_addr;
              nxt_dout = old_base_ff;
            end
            4'hA: begin
              nxt_rd = 1'b1;
              unique case (src_ff)
                ctx_switch_pkg::SRC_RESET: nxt_addr = ctx_switch_pkg::RESET_PC_ADDR;
                ctx_switch_pkg::SRC_LOAD:  nxt_addr = ctx_switch_pkg::LOAD_PC_ADDR;
                default:                   nxt_addr = vec_ff + ctx_switch_pkg::PC_STEP;
              endcase
            end
            default: begin
            end
          endcase
        end else begin
          // Final ALU cycle ends the switch; address bus keeps its value
          nxt_state = ctx_switch_pkg::ST_RUN;
          nxt_upd   = 1'b1;
        end
        if (rd_ff && step == 4'h2) begin
          nxt_base = data_bus_in;
        end
        if (rd_ff && step == 4'hA) begin
          nxt_pc = data_bus_in;
        end
      end
      default: begin
        nxt_state = ctx_switch_pkg::ST_HOLD;
      end
    endcase
    if (srst || reset_active) begin
      nxt_state = ctx_switch_pkg::ST_HOLD;
      nxt_src   = ctx_switch_pkg::SRC_RESET;
      nxt_cyc   = 4'h0;
      nxt_rd    = 1'b0;
      nxt_wr    = 1'b0;
      nxt_oe_n  = 1'b1;
      nxt_upd   = 1'b0;
    end
    if (srst) begin
      nxt_base       = ctx_switch_pkg::RESET_WP_VALUE;
      nxt_pc         = ctx_switch_pkg::RESET_PC_VALUE;
      nxt_old_status = ctx_switch_pkg::RESET_ST_VALUE;
      nxt_old_pc     = ctx_switch_pkg::RESET_PC_VALUE;
      nxt_old_base   = ctx_switch_pkg::RESET_WP_VALUE;
      nxt_vec        = ctx_switch_pkg::ZERO_WORD;
      nxt_addr       = ctx_switch_pkg::ZERO_WORD;
      nxt_dout       = ctx_switch_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_ff      <= nxt_state;
    src_ff        <= nxt_src;
    cyc_ff        <= nxt_cyc;
    base_ff       <= nxt_base;
    pc_ff         <= nxt_pc;
    old_status_ff <= nxt_old_status;
    old_pc_ff     <= nxt_old_pc;
    old_base_ff   <= nxt_old_base;
    vec_ff        <= nxt_vec;
    addr_ff       <= nxt_addr;
    dout_ff       <= nxt_dout;
    oe_n_ff       <= nxt_oe_n;
    rd_ff         <= nxt_rd;
    wr_ff         <= nxt_wr;
    upd_ff        <= nxt_upd;
  end

  assign address_bus   = addr_ff;
  assign data_bus_out  = dout_ff;
  assign data_bus_oe_n = oe_n_ff;
  assign mem_read      = rd_ff;
  assign mem_write     = wr_ff;
  assign seq_busy      = (state_ff != ctx_switch_pkg::ST_RUN);
  assign core_hold     = seq_busy;
  assign intr_ack      = (state_ff == ctx_switch_pkg::ST_RUN) && start_exc && !load_req;
  assign load_ack      = (state_ff == ctx_switch_pkg::ST_RUN) && start_exc && load_req;
  assign ctx_update    = upd_ff;
  assign new_base      = base_ff;
  assign new_pc        = pc_ff;
endmodule

// ==== core/reset_release_detect.sv ====
// Purpose: Synchronises the reset pin and reports its release
// Assumes: Pin is asynchronous to sys_clk, active low
// Notes:   Release only counts after the pin was seen low long enough
`timescale 1ns/1ns
module reset_release_detect (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic reset_pin_n,
  output logic      reset_active,
  output logic      reset_release
);
  logic       sync1_ff;
  logic       sync2_ff;
  logic [1:0] low_cnt_ff;
  logic       nxt_sync1;
  logic       nxt_sync2;
  logic [1:0] nxt_low_cnt;

  always_comb begin
    nxt_sync1   = reset_pin_n;
    nxt_sync2   = sync1_ff;
    nxt_low_cnt = low_cnt_ff;
    if (!sync2_ff) begin
      if (low_cnt_ff != ctx_switch_pkg::RESET_HOLD_MIN) begin
        nxt_low_cnt = low_cnt_ff + 2'h1;
      end
    end else begin
      nxt_low_cnt = 2'h0;
    end
    if (srst) begin
      nxt_sync1   = 1'b1;
      nxt_sync2   = 1'b1;
      nxt_low_cnt = 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    sync1_ff   <= nxt_sync1;
    sync2_ff   <= nxt_sync2;
    low_cnt_ff <= nxt_low_cnt;
  end

  assign reset_active  = !sync2_ff;
  // Shorter pulses still raise reset_active but never report a release
  assign reset_release = sync2_ff && (low_cnt_ff == ctx_switch_pkg::RESET_HOLD_MIN);
endmodule

// ==== core/slot_address_gen.sv ====
// Purpose: Forms the three save slot addresses from a workspace base
// Assumes: Slot n sits at base plus two times n
// Notes:   Pure combinational adders
`timescale 1ns/1ns
module slot_address_gen (
  input  wire logic [15:0] base,
  output logic      [15:0] status_slot_addr,
  output logic      [15:0] return_slot_addr,
  output logic      [15:0] saved_base_addr
);
  assign status_slot_addr = base + ctx_switch_pkg::SLOT15_OFFSET;
  assign return_slot_addr = base + ctx_switch_pkg::SLOT14_OFFSET;
  assign saved_base_addr  = base + ctx_switch_pkg::SLOT13_OFFSET;
endmodule

// ==== inc/ctx_switch_pkg.sv ====
// Purpose: Shared constants and types for the context switch sequencer
// Assumes: 16-bit word-addressed-by-byte memory bus, one machine cycle per clock
// Notes:   Cycle counts are per sequence, counted from 1
package ctx_switch_pkg;
  localparam int unsigned     DATA_W          = 16;
  localparam logic [15:0]     RESET_WP_ADDR   = 16'h0000;
  localparam logic [15:0]     RESET_PC_ADDR   = 16'h0002;
  localparam logic [15:0]     LOAD_WP_ADDR    = 16'hFFFC;
  localparam logic [15:0]     LOAD_PC_ADDR    = 16'hFFFE;
  localparam logic [15:0]     SLOT15_OFFSET   = 16'h001E;
  localparam logic [15:0]     SLOT14_OFFSET   = 16'h001C;
  localparam logic [15:0]     SLOT13_OFFSET   = 16'h001A;
  localparam logic [15:0]     PC_STEP         = 16'h0002;
  localparam logic [15:0]     ZERO_WORD       = 16'h0000;
  localparam logic [3:0]      RESET_LEN       = 4'hD;
  localparam logic [3:0]      EXC_LEN         = 4'hB;
  localparam logic [1:0]      RESET_HOLD_MIN  = 2'h3;
  localparam logic [15:0]     RESET_WP_VALUE  = 16'h0000;
  localparam logic [15:0]     RESET_PC_VALUE  = 16'h0000;
  localparam logic [15:0]     RESET_ST_VALUE  = 16'h0000;

  typedef enum logic [1:0] {
    CYC_ALU   = 2'h0,
    CYC_READ  = 2'h1,
    CYC_WRITE = 2'h3
  } cycle_kind_t;

  typedef enum logic [1:0] {
    SRC_RESET = 2'h0,
    SRC_LOAD  = 2'h1,
    SRC_INTR  = 2'h3
  } switch_src_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_SEQ   = 2'h1,
    ST_HOLD  = 2'h3
  } seq_state_t;
endpackage

// ==== verification/context_switch_sequencer_tb_top.sv ====
// Purpose: Self-checking bench for the context switch sequencer
// Assumes: Bases kept clear of vectors so saves never hit a fetch word
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ns
module context_switch_sequencer_tb_top;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
  logic        sys_clk = 1'b0;
  logic        srst, reset_pin_n, load_req, intr_req, instr_last_cycle;
  logic [15:0] intr_vector_addr, cur_status, cur_pc, cur_base, data_bus_in;
  logic [15:0] address_bus, data_bus_out, new_base, new_pc;
  logic        data_bus_oe_n, mem_read, mem_write, seq_busy, intr_ack, load_ack;
  logic        ctx_update, core_hold;
  logic [31:0] seed = 32'h00017934;
  int          n_errors = 0;
  int          check_count = 0;
  always #5 sys_clk = ~sys_clk;
  context_switch_sequencer dut (.sys_clk(sys_clk), .srst(srst), .reset_pin_n(reset_pin_n),
    .load_req(load_req), .intr_req(intr_req), .intr_vector_addr(intr_vector_addr),
    .instr_last_cycle(instr_last_cycle), .cur_status(cur_status), .cur_pc(cur_pc),
    .cur_base(cur_base), .data_bus_in(data_bus_in), .address_bus(address_bus),
    .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n), .mem_read(mem_read),
    .mem_write(mem_write), .seq_busy(seq_busy), .intr_ack(intr_ack), .load_ack(load_ack),
    .ctx_update(ctx_update), .new_base(new_base), .new_pc(new_pc), .core_hold(core_hold));
  ctx_mem_model mdl (.sys_clk(sys_clk), .address_bus(address_bus),
    .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n), .mem_read(mem_read),
    .mem_write(mem_write), .data_bus_in(data_bus_in));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [14:0] slot(input logic [15:0] b, input logic [15:0] n);
    logic [15:0] a;
    a = b + (n << 1);
    return a[15:1];
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Sets a random old context and plants the new one at the fetch address
  task automatic setup(input logic [15:0] fa, output logic [15:0] wp, output logic [15:0] pc);
    wp = 16'h4000 | (rnd() & 16'h3FFE);
    pc = rnd() & 16'hFFFE;
    mdl.mem[fa[15:1]] = wp;
    mdl.mem[fa[15:1] + 15'h0001] = pc;
    cur_status = rnd();
    cur_pc = rnd();
    cur_base = rnd();
  endtask
  task automatic finish_switch(input logic [15:0] wp, input logic [15:0] pc);
    int n;
    n = 0;
    while (ctx_update !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(n < 20, 1'b1)
    `CHK(new_base, wp)
    `CHK(new_pc, pc)
    `CHK(mdl.mem[slot(wp, 16'h000F)], cur_status)
    `CHK(mdl.mem[slot(wp, 16'h000E)], cur_pc + 16'h0002)
    `CHK(mdl.mem[slot(wp, 16'h000D)], cur_base)
  endtask
  // Kind bit 0 asks for a load, bit 1 for an interrupt
  task automatic run_switch(input logic [1:0] kind);
    logic [15:0] wp, pc;
    intr_vector_addr = 16'h0100 | (rnd() & 16'h0FFC);
    setup(kind[0] ? 16'hFFFC : intr_vector_addr, wp, pc);
    load_req = kind[0];
    intr_req = kind[1];
    instr_last_cycle = 1'b0;
    @(negedge sys_clk);
    `CHK({load_ack, intr_ack}, 2'b00)
    instr_last_cycle = 1'b1;
    #1;
    `CHK({load_ack, intr_ack}, {kind[0], ~kind[0]})
    @(negedge sys_clk);
    `CHK({load_ack, intr_ack, seq_busy, core_hold}, 4'b0011)
    load_req = 1'b0;
    intr_req = 1'b0;
    instr_last_cycle = 1'b0;
    finish_switch(wp, pc);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] wp, pc;
    srst = 1'b1;
    reset_pin_n = 1'b0;
    {load_req, intr_req, instr_last_cycle} = 3'b000;
    intr_vector_addr = 16'h0000;
    setup(16'h0000, wp, pc);
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK(seq_busy, 1'b1)
    reset_pin_n = 1'b1;
    finish_switch(wp, pc);
    run_switch(2'h1);
    run_switch(2'h2);
    run_switch(2'h3);
    repeat (40) run_switch(2'(16'h0001 + rnd() % 16'h0003));
    tally_and_finish();
  end
endmodule

// ==== verification/ctx_mem_model.sv ====
// Purpose: Word memory on the far side of the address and data bus
// Assumes: Reads answer in the same cycle, writes land at the clock edge
// Notes:   An idle bus shows the inverse of the last word read
`timescale 1ns/1ns
module ctx_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] address_bus,
  input  wire logic [15:0] data_bus_out,
  input  wire logic        data_bus_oe_n,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  output logic      [15:0] data_bus_in
);
  logic [15:0] mem [0:32767];
  logic [15:0] last_ff = 16'h0000;
  always @(posedge sys_clk) begin
    if (mem_write && !data_bus_oe_n) begin
      mem[address_bus[15:1]] <= data_bus_out;
    end
    if (mem_read) begin
      last_ff <= data_bus_in;
    end
  end
  assign data_bus_in = mem_read ? mem[address_bus[15:1]] : ~last_ff;
endmodule

// ==== verification/ctx_switch_monitor.sv ====
// Purpose: Port checks for the context switch sequencer
// Assumes: Interrupt vectors never sit at address zero
// Notes:   Cycle N of a sequence is sampled N edges after the accept edge
`timescale 1ns/1ns
module ctx_switch_monitor (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        reset_pin_n,
  input wire logic        instr_last_cycle,
  input wire logic [15:0] intr_vector_addr,
  input wire logic [15:0] data_bus_in,
  input wire logic [15:0] address_bus,
  input wire logic [15:0] data_bus_out,
  input wire logic        data_bus_oe_n,
  input wire logic        mem_read,
  input wire logic        mem_write,
  input wire logic        seq_busy,
  input wire logic        intr_ack,
  input wire logic        load_ack,
  input wire logic        ctx_update
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_base_fetch;
    mem_read ##2 mem_write;
  endsequence
  a_reset_start: assert property ($rose(reset_pin_n) |-> ##[4:7] mem_read && address_bus == 16'h0000)
    else $error("reset sequence late");
  a_reset_zero: assert property (mem_read && address_bus == 16'h0000 |->
    $past(address_bus == 16'h0000 && data_bus_out == 16'h0000 && !data_bus_oe_n))
    else $error("no zero cycle before base fetch");
  a_reset_pc: assert property (mem_read && address_bus == 16'h0000 |->
    ##8 mem_read && address_bus == 16'h0002)
    else $error("reset pc fetch wrong");
  a_load_base: assert property (load_ack |-> ##2 mem_read && address_bus == 16'hFFFC)
    else $error("load base fetch wrong");
  a_load_pc: assert property (load_ack |-> ##10 mem_read && address_bus == 16'hFFFE)
    else $error("load pc fetch wrong");
  a_intr_base: assert property (intr_ack |->
    ##2 mem_read && address_bus == $past(intr_vector_addr, 2))
    else $error("vector base fetch wrong");
  a_intr_pc: assert property (intr_ack |->
    ##10 mem_read && address_bus == $past(intr_vector_addr, 10) + 16'h0002)
    else $error("vector pc fetch wrong");
  a_switch_len: assert property (load_ack || intr_ack |-> ##[11:12] ctx_update)
    else $error("switch length wrong");
  a_ack_boundary: assert property (load_ack || intr_ack |->
    instr_last_cycle && !seq_busy ##1 seq_busy)
    else $error("accept off boundary");
  a_slot_chain: assert property (s_base_fetch |->
    address_bus == $past(data_bus_in, 2) + 16'h001E
    ##2 mem_write && address_bus == $past(data_bus_in, 4) + 16'h001C
    ##2 mem_write && address_bus == $past(data_bus_in, 6) + 16'h001A)
    else $error("save slot order wrong");
  a_bus_dir: assert property (mem_read || mem_write |-> data_bus_oe_n == mem_read)
    else $error("data bus direction wrong");
  c_load: cover property (load_ack);
  c_intr: cover property (intr_ack);
  c_done: cover property (ctx_update);
endmodule

bind context_switch_sequencer ctx_switch_monitor u_mon (.*);
